// ==== logic/ubrg_defines.vh ====
// How it works
// RULE1: Generator runs from the reference clock input, crystal or external source.
// RULE2: Sample rate is reference divided by divisor times prescaler; divisor is low plus 256*high.
// RULE3: Prescaler equals two to the exponent times (sample count plus offset).
// RULE4: Sample count is 16 minus the sample count register, register 0h to Ch.
// RULE5: Prescale exponent comes straight from its register, valid 01h or 02h.
// RULE6: Prescale offset comes straight from its register, 0h to 7h, added to sample count.
// RULE7: Software must not program a zero sample count, divisor or prescaler.
// RULE8: Sample count and prescaler apply only in enhanced mode; otherwise fixed sixteen; the logic fixes the legacy prescaler at one.
// RULE9: One sample tick per prescaled period; each bit spans sample-count ticks.
`ifndef UBRG_DEFINES_VH
`define UBRG_DEFINES_VH
`define UBRG_OFS_DIV_LOW 8'h00
`define UBRG_OFS_DIV_HIGH 8'h04
`define UBRG_OFS_SAMPLE 8'h08
`define UBRG_OFS_EXP 8'h0C
`define UBRG_OFS_OFFSET 8'h10
`define UBRG_OFS_CTRL 8'h14
`define UBRG_OFS_STATUS 8'h18
`define UBRG_RST_DIV_LOW 8'h01
`define UBRG_RST_DIV_HIGH 8'h00
`define UBRG_RST_SAMPLE 4'h0
`define UBRG_RST_EXP 2'h1
`define UBRG_RST_OFFSET 3'h0
`define UBRG_SAMPLE_BASE 5'h10
`define UBRG_SAMPLE_MAX 4'hC
`define UBRG_LEGACY_COUNT 5'h10
`define UBRG_CTRL_ENH_BIT 0
`define UBRG_CTRL_EN_BIT 1
`define UBRG_RESP_OKAY 2'h0
`define UBRG_RESP_SLVERR 2'h2
`endif

// ==== logic/ubrg_counter.v ====
`timescale 1ns/1ps
`include "ubrg_defines.vh"
// Reloadable down counter: pulses tick once every load_value+1 enabled steps
module ubrg_counter #(
    parameter WIDTH = 16
) (
    input wire aclk, // System clock
    input wire aresetn, // Synchronous reset, active low
    input wire enable, // Count this cycle
    input wire restart, // Force reload
    input wire [WIDTH-1:0] load_value, // Period minus one
    output reg tick // One-cycle pulse at period end
);
    reg [WIDTH-1:0] count;

    // Count down, reload at zero
    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= {WIDTH{1'b0}};
            tick <= 1'b0;
        end else if (restart) begin
            count <= load_value;
            tick <= 1'b0;
        end else if (enable) begin
            if (count == {WIDTH{1'b0}}) begin
                count <= load_value;
                tick <= 1'b1;
            end else begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                tick <= 1'b0;
            end
        end else begin
            tick <= 1'b0;
        end
    end
endmodule

// ==== logic/ubrg_top.v ====
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ubrg_defines.vh"
// Bit rate generator with AXI4-Lite register slave
module ubrg_top (
    input wire aclk, // System clock, 20 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire reference_clock_in, // Reference clock pin
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    output wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    output wire s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    output wire s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output reg sample_tick, // One pulse per prescaled divisor period
    output reg bit_tick // One pulse per serial bit
);
    reg [7:0] divisor_low_byte;
    reg [7:0] divisor_high_byte;
    reg [3:0] sample_count_register;
    reg [1:0] prescale_exponent;
    reg [2:0] prescale_offset;
    reg enhanced_mode;
    reg generator_enable;
    reg aw_held;
    reg [7:0] aw_addr;
    reg w_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [2:0] ref_sync;
    reg ref_level;
    reg ref_rise;
    reg restart;
    reg [8:0] prescale_step;
    reg [4:0] bit_step;
    wire [15:0] divisor;
    wire [4:0] sample_count;
    wire [5:0] base_count;
    wire [8:0] prescaler;
    wire [15:0] div_load;
    wire div_tick;
    wire do_write;
    wire [7:0] wb;

    // Divisor assembled from both bytes
    assign divisor = {divisor_high_byte, divisor_low_byte}; // RULE2
    // Sample count: enhanced programmable, else legacy sixteen
    assign sample_count = enhanced_mode ?
        (`UBRG_SAMPLE_BASE - {1'b0, sample_count_register}) : `UBRG_LEGACY_COUNT; // RULE4 RULE8
    // Prescaler: 2^M times (count plus offset) in enhanced mode, else one
    assign base_count = {1'b0, sample_count} + {3'b000, prescale_offset}; // RULE6
    assign prescaler = enhanced_mode ? ({3'b000, base_count} << prescale_exponent) : 9'h001; // RULE3 RULE5 RULE8
    assign div_load = divisor - 16'h0001;

    // Write channels accepted independently
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wb = w_strb[0] ? w_data[7:0] : 8'h00;

    // Reference pin synchroniser, a change counts once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            ref_sync <= 3'b000;
            ref_level <= 1'b0;
            ref_rise <= 1'b0;
        end else begin
            ref_sync <= {ref_sync[1:0], reference_clock_in}; // RULE1
            ref_rise <= 1'b0;
            if (ref_sync[2] == ref_sync[1] && ref_sync[2] != ref_level) begin
                ref_level <= ref_sync[2];
                ref_rise <= ref_sync[2];
            end
        end
    end

    // Divisor stage counts rising reference edges
    ubrg_counter #(
        .WIDTH(16)
    ) u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(ref_rise && generator_enable),
        .restart(restart),
        .load_value(div_load),
        .tick(div_tick)
    );

    // Prescaler stage: sample tick every prescaler divisor periods
    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            prescale_step <= 9'h000;
            bit_step <= 5'h00;
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            sample_tick <= 1'b0;
            bit_tick <= 1'b0;
            if (div_tick) begin
                if (prescale_step + 9'h001 >= prescaler) begin // RULE3
                    prescale_step <= 9'h000;
                    sample_tick <= 1'b1; // RULE9
                    if (bit_step + 5'h01 >= sample_count) begin
                        bit_step <= 5'h00;
                        bit_tick <= 1'b1; // RULE9
                    end else begin
                        bit_step <= bit_step + 5'h01;
                    end
                end else begin
                    prescale_step <= prescale_step + 9'h001;
                end
            end
        end
    end


    // Write path and registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UBRG_RESP_OKAY;
            divisor_low_byte <= `UBRG_RST_DIV_LOW;
            divisor_high_byte <= `UBRG_RST_DIV_HIGH;
            sample_count_register <= `UBRG_RST_SAMPLE;
            prescale_exponent <= `UBRG_RST_EXP;
            prescale_offset <= `UBRG_RST_OFFSET;
            enhanced_mode <= 1'b0;
            generator_enable <= 1'b0;
            restart <= 1'b0;
        end else begin
            restart <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `UBRG_RESP_OKAY;
                restart <= 1'b1;
                case ({aw_addr[7:2], 2'b00})
                    `UBRG_OFS_DIV_LOW: begin
                        if (w_strb[0]) divisor_low_byte <= wb;
                    end
                    `UBRG_OFS_DIV_HIGH: begin
                        if (w_strb[0]) divisor_high_byte <= wb;
                    end
                    `UBRG_OFS_SAMPLE: begin
                        if (w_strb[0] && wb[3:0] <= `UBRG_SAMPLE_MAX) sample_count_register <= wb[3:0];
                    end
                    `UBRG_OFS_EXP: begin
                        if (w_strb[0] && (wb[1:0] == 2'h1 || wb[1:0] == 2'h2)) prescale_exponent <= wb[1:0];
                    end
                    `UBRG_OFS_OFFSET: begin
                        if (w_strb[0]) prescale_offset <= wb[2:0];
                    end
                    `UBRG_OFS_CTRL: begin
                        if (w_strb[0]) begin
                            enhanced_mode <= wb[`UBRG_CTRL_ENH_BIT];
                            generator_enable <= wb[`UBRG_CTRL_EN_BIT];
                        end
                    end
                    `UBRG_OFS_STATUS: begin
                        restart <= 1'b0;
                    end
                    default: begin
                        restart <= 1'b0;
                        s_axi_bresp <= `UBRG_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Read path, answer one cycle after address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UBRG_RESP_OKAY;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `UBRG_RESP_OKAY;
                case ({s_axi_araddr[7:2], 2'b00})
                    `UBRG_OFS_DIV_LOW: s_axi_rdata <= {24'h00_0000, divisor_low_byte};
                    `UBRG_OFS_DIV_HIGH: s_axi_rdata <= {24'h00_0000, divisor_high_byte};
                    `UBRG_OFS_SAMPLE: s_axi_rdata <= {28'h000_0000, sample_count_register};
                    `UBRG_OFS_EXP: s_axi_rdata <= {30'h0000_0000, prescale_exponent};
                    `UBRG_OFS_OFFSET: s_axi_rdata <= {29'h0000_0000, prescale_offset};
                    `UBRG_OFS_CTRL: s_axi_rdata <= {30'h0000_0000, generator_enable, enhanced_mode};
                    `UBRG_OFS_STATUS: s_axi_rdata <= {14'h0000, ref_level, prescaler, bit_step, 3'h0};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `UBRG_RESP_SLVERR;
                    end
                endcase
            end
        end
    end
endmodule

// ==== sim/ubrg_checker.sv ====
`timescale 1ns/1ps
// Port watcher for the bit rate generator
module ubrg_checker (
    input wire aclk, // Clock
    input wire aresetn, // Reset, active low
    input wire reference_clock_in, // Reference pin
    input wire [7:0] s_axi_awaddr, // Write address
    input wire s_axi_awvalid, // Write address valid
    input wire s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write strobes
    input wire s_axi_wvalid, // Write data valid
    input wire s_axi_wready, // Write data ready
    input wire [1:0] s_axi_bresp, // Write response
    input wire s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [7:0] s_axi_araddr, // Read address
    input wire s_axi_arvalid, // Read address valid
    input wire s_axi_arready, // Read address ready
    input wire [31:0] s_axi_rdata, // Read data
    input wire [1:0] s_axi_rresp, // Read response
    input wire s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    input wire sample_tick, // Sample tick
    input wire bit_tick // Bit tick
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Tick relations
    tick_gap_a: assert property (sample_tick |=> !sample_tick) else $error("sample tick too long");
    bit_on_sample_a: assert property (bit_tick |-> sample_tick) else $error("bit tick off sample");
    bit_spacing_a: assert property (bit_tick |=> !bit_tick [*7]) else $error("bit ticks too close");
    // Register bus answers
    b_stands_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > 6'h06
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
    b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    cover property (bit_tick);
    cover property (sample_tick && !bit_tick);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind ubrg_top ubrg_checker u_chk (.aclk(aclk), .aresetn(aresetn), .reference_clock_in(reference_clock_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_araddr(s_axi_araddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_rdata(s_axi_rdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_tick(sample_tick), .bit_tick(bit_tick));

// ==== sim/ubrg_top_tb.sv ====
`timescale 1ns/1ps
`include "ubrg_defines.vh"
// Register-level bench for the bit rate generator
module ubrg_top_tb;
    logic aclk = 1'b0, aresetn = 1'b0, refc = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rd;
    logic [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, sample_tick, bit_tick;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int errors = 0, checked = 0, cyc = 0, sp, bp, i, pre, cnt;
    logic [11:0] cfg [5] = '{12'hC10, 12'hC20, 12'hC14, 12'hA12, 12'h827}; // Sample reg, exponent, offset
    logic [31:0] rst_v [6] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000,
        32'h0000_0000};
    ubrg_top dut (.aclk(aclk), .aresetn(aresetn), .reference_clock_in(refc), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sample_tick(sample_tick), .bit_tick(bit_tick));
    always #25 aclk = ~aclk;
    // Reference clock at one eighth of aclk, and the run limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc % 4 == 3) refc <= ~refc;
        if (cyc == 40000) begin
            errors = errors + 1;
            summarize();
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (awvalid || wvalid || bvalid !== 1'b1) begin
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            @(posedge aclk);
        end
        rs = bresp;
        bready <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arvalid || rvalid !== 1'b1) begin
            if (arready === 1'b1) arvalid <= 1'b0;
            @(posedge aclk);
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // Cycles from one tick to the next sample tick and to the next tick of the same kind
    task meas(input bit full);
        sp = 0;
        bp = 0;
        @(negedge aclk);
        while ((full ? bit_tick : sample_tick) !== 1'b1) @(negedge aclk);
        do begin
            @(negedge aclk);
            bp++;
            if (sample_tick === 1'b1 && sp == 0) sp = bp;
        end while ((full ? bit_tick : sample_tick) !== 1'b1);
    endtask
    task summarize();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 6; i++) begin
            rdr(8'(i * 4));
            chk("reset value", rd, rst_v[i]);
            chk("read response", 32'(rs), `UBRG_RESP_OKAY);
        end
        $display("reset values done");
        rdr(8'h1C);
        chk("unmapped read", 32'(rs), `UBRG_RESP_SLVERR);
        wr(8'h1C, 32'h0000_0001);
        chk("unmapped write", 32'(rs), `UBRG_RESP_SLVERR);
        wr(`UBRG_OFS_SAMPLE, 32'h0000_000D);
        rdr(`UBRG_OFS_SAMPLE);
        chk("sample count", rd, 32'h0000_0000);
        wr(`UBRG_OFS_EXP, 32'h0000_0003);
        chk("refused write response", 32'(rs), `UBRG_RESP_OKAY);
        rdr(`UBRG_OFS_EXP);
        chk("exponent", rd, 32'h0000_0001);
        $display("field limits done");
        // Legacy mode keeps sixteen ticks per bit and no prescale
        wr(`UBRG_OFS_SAMPLE, 32'h0000_000C);
        wr(`UBRG_OFS_EXP, 32'h0000_0002);
        wr(`UBRG_OFS_DIV_LOW, 32'h0000_0003);
        wr(`UBRG_OFS_CTRL, 32'h0000_0002);
        meas(1'b1);
        chk("legacy sample period", sp, 3 * 8);
        chk("legacy bit period", bp, 3 * 8 * 16);
        $display("legacy mode done");
        wr(`UBRG_OFS_DIV_LOW, 32'h0000_0001);
        wr(`UBRG_OFS_CTRL, 32'h0000_0003);
        for (i = 0; i < 5; i++) begin
            cnt = 16 - cfg[i][11:8];
            pre = (1 << cfg[i][7:4]) * (cnt + cfg[i][3:0]);
            wr(`UBRG_OFS_SAMPLE, 32'(cfg[i][11:8]));
            wr(`UBRG_OFS_EXP, 32'(cfg[i][7:4]));
            wr(`UBRG_OFS_OFFSET, 32'(cfg[i][3:0]));
            rdr(`UBRG_OFS_STATUS);
            chk("prescaler field", (rd >> 8) & 32'h0000_01FF, 32'(pre));
            meas(1'b1);
            chk("enhanced sample period", sp, pre * 8);
            chk("enhanced bit period", bp, pre * 8 * cnt);
        end
        $display("enhanced mode done");
        // High byte first so the divisor never passes through zero
        wr(`UBRG_OFS_CTRL, 32'h0000_0002);
        wr(`UBRG_OFS_DIV_HIGH, 32'h0000_0001);
        wr(`UBRG_OFS_DIV_LOW, 32'h0000_0000);
        meas(1'b0);
        chk("high divisor period", sp, 256 * 8);
        $display("divisor high byte done");
        summarize();
    end
endmodule
